// file: core/sdos_cond.v
`timescale 1ns/1ps
`include "sdos_regs.vh"
// ----------------------------------------
// condition selection for one contact
// ----------------------------------------
module sdos_cond #(
    parameter POS_W = 16
) (
    input wire [2:0] sel, // condition selector code
    input wire failsafe, // device in failsafe
    input wire reset_flag, // latched reset-occurred flag
    input wire pos_err, // position error present
    input wire tso_en, // tight shutoff enabled
    input wire [POS_W-1:0] tso_thr, // tight shutoff threshold
    input wire [POS_W-1:0] pos, // measured valve position
    input wire [POS_W-1:0] lim_low, // low limit of this contact
    input wire [POS_W-1:0] lim_high, // high limit of this contact
    input wire manual, // manual mode
    output reg asserted // selected condition is active
);
    // pick the status flag for the selected code
    always @* begin
        case (sel)
            `SDOS_SEL_NORMAL: asserted = 1'b0;
            `SDOS_SEL_FAILSAFE: asserted = failsafe;
            `SDOS_SEL_RESET: asserted = reset_flag;
            `SDOS_SEL_POSERR: asserted = pos_err;
            `SDOS_SEL_TSO: asserted = tso_en && (pos < tso_thr);
            `SDOS_SEL_LOW: asserted = pos < lim_low;
            `SDOS_SEL_HIGH: asserted = pos > lim_high;
            `SDOS_SEL_MANUAL: asserted = manual;
            default: asserted = 1'b0;
        endcase
    end
endmodule

// file: core/sdos_regs.vh
`ifndef SDOS_REGS_VH
`define SDOS_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SDOS_OFS_CFG_A 8'h00
`define SDOS_OFS_CFG_B 8'h04
`define SDOS_OFS_LIM_A 8'h08
`define SDOS_OFS_LIM_B 8'h0C
`define SDOS_OFS_TSO 8'h10
`define SDOS_OFS_STATUS 8'h14
`define SDOS_OFS_MASK 8'h18
`define SDOS_OFS_STATE 8'h1C
// ----------------------------------------
// configuration field layout
// ----------------------------------------
`define SDOS_CFG_SEL_LSB 0
`define SDOS_CFG_SEL_MSB 2
`define SDOS_CFG_POL_BIT 3
// ----------------------------------------
// condition selector codes
// ----------------------------------------
`define SDOS_SEL_NORMAL 3'h0
`define SDOS_SEL_FAILSAFE 3'h1
`define SDOS_SEL_RESET 3'h2
`define SDOS_SEL_POSERR 3'h3
`define SDOS_SEL_TSO 3'h4
`define SDOS_SEL_LOW 3'h5
`define SDOS_SEL_HIGH 3'h6
`define SDOS_SEL_MANUAL 3'h7
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define SDOS_ST_RESET 0
`define SDOS_ST_CHG_A 1
`define SDOS_ST_CHG_B 2
`define SDOS_ST_WIDTH 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define SDOS_CFG_RST 4'h0
`define SDOS_LIM_LOW_RST 16'h0000
`define SDOS_LIM_HIGH_RST 16'hFFFF
`define SDOS_TSO_RST 17'h00000
`define SDOS_MASK_RST 3'h0
`endif

// file: core/sdos_sync2.v
`timescale 1ns/1ps
// ----------------------------------------
// two flop synchroniser, per bit
// ----------------------------------------
module sdos_sync2 #(
    parameter WIDTH = 1
) (
    input wire hclk, // system clock
    input wire hresetn, // async reset, active low
    input wire [WIDTH-1:0] d_in, // asynchronous input
    output wire [WIDTH-1:0] q_out // synchronised output
);
    reg [WIDTH-1:0] meta_reg; // first stage, read only by second
    reg [WIDTH-1:0] sync_reg; // second stage

    // two stages, nothing taps the first
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule

// file: core/sdos_top.v
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sdos_regs.vh"
// What this block does
// - two contacts, each with own selector
// - code 0 keeps contact at normal
// - defaults: selector 0, normal is closed
// - code 1 follows failsafe state
// - code 2 latches reset until cleared
// - code 3 follows position error
// - code 4: tight shutoff and below threshold
// - code 5: position below low limit
// - code 6: position above high limit
// - code 7 follows manual mode
// - contacts open when unpowered
// - per-contact polarity picks open or closed
// - contacts follow status, not software writes
module sdos_top #(
    parameter POS_W = 16
) (
    input wire hclk, // system clock, 20 MHz
    input wire hresetn, // async reset, active low
    input wire hsel, // slave select
    input wire [7:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write strobe
    input wire [2:0] hsize, // transfer size
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready in
    output reg [31:0] hrdata, // read data
    output reg hreadyout, // slave ready
    output reg hresp, // response, always okay
    input wire power_good, // supply present, async
    input wire failsafe_in, // failsafe mode, async
    input wire pos_err_in, // position error, async
    input wire manual_in, // manual mode, async
    input wire [POS_W-1:0] pos_in, // measured position, same clock
    output reg contact_out_a, // contact a, 1 = closed
    output reg contact_out_b, // contact b, 1 = closed
    output reg irq // interrupt, active high level
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [3:0] cfg_a_reg; // contact a selector and polarity
    reg [3:0] cfg_b_reg; // contact b selector and polarity
    reg [31:0] lim_a_reg; // a: high limit [31:16], low [15:0]
    reg [31:0] lim_b_reg; // b: high limit [31:16], low [15:0]
    reg [16:0] tso_reg; // bit 16 enable, threshold below
    reg [2:0] status_reg; // sticky events
    reg [2:0] status_next; // next sticky events
    reg [2:0] mask_reg; // interrupt mask
    reg reset_flag_reg; // reset occurred, held until cleared
    reg wr_pend_reg; // write data phase pending
    reg [7:0] wr_addr_reg; // latched write address
    reg [31:0] rd_data_next; // read mux
    wire [3:0] sync_q; // synchronised async inputs
    wire pwr_s; // power good, synchronised
    wire fs_s; // failsafe, synchronised
    wire pe_s; // position error, synchronised
    wire man_s; // manual mode, synchronised
    wire [1:0] cond; // per-contact asserted condition
    wire [1:0] close_next; // per-contact next closed state
    wire [1:0] cur_out; // current contact outputs
    wire [3:0] cfg_w [0:1]; // config per contact
    wire [31:0] lim_w [0:1]; // limits per contact
    wire addr_ok; // valid address phase
    wire rd_take; // read accepted this cycle
    wire stat_read; // read of status register

    assign addr_ok = hsel && hready && htrans[1];
    assign rd_take = addr_ok && !hwrite;
    assign stat_read = rd_take && (haddr == `SDOS_OFS_STATUS);
    assign cfg_w[0] = cfg_a_reg;
    assign cfg_w[1] = cfg_b_reg;
    assign lim_w[0] = lim_a_reg;
    assign lim_w[1] = lim_b_reg;
    assign cur_out = {contact_out_b, contact_out_a};

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    sdos_sync2 #(
        .WIDTH(4)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d_in({manual_in, pos_err_in, failsafe_in, power_good}),
        .q_out(sync_q)
    );
    assign pwr_s = sync_q[0];
    assign fs_s = sync_q[1];
    assign pe_s = sync_q[2];
    assign man_s = sync_q[3];

    // ----------------------------------------
    // per-contact condition and polarity
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_contact
            // condition picked from own selector
            sdos_cond #(
                .POS_W(POS_W)
            ) u_cond (
                .sel(cfg_w[gi][`SDOS_CFG_SEL_MSB:`SDOS_CFG_SEL_LSB]),
                .failsafe(fs_s),
                .reset_flag(reset_flag_reg),
                .pos_err(pe_s),
                .tso_en(tso_reg[16]),
                .tso_thr(tso_reg[POS_W-1:0]),
                .pos(pos_in),
                .lim_low(lim_w[gi][POS_W-1:0]),
                .lim_high(lim_w[gi][16+POS_W-1:16]),
                .manual(man_s),
                .asserted(cond[gi])
            );
            // normal closed; asserted goes to polarity, unpowered open
            assign close_next[gi] = pwr_s &&
                (cond[gi] ? cfg_w[gi][`SDOS_CFG_POL_BIT] : 1'b1);
        end
    endgenerate

    // ----------------------------------------
    // contact outputs
    // ----------------------------------------
    // outputs re-evaluated every cycle, open in reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            contact_out_a <= 1'b0;
            contact_out_b <= 1'b0;
        end else begin
            contact_out_a <= close_next[0];
            contact_out_b <= close_next[1];
        end
    end

    // ----------------------------------------
    // ahb-lite slave: write path
    // ----------------------------------------
    // latch write address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok && hwrite) begin
                wr_addr_reg <= haddr;
            end
        end
    end

    // configuration registers, written in data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_a_reg <= `SDOS_CFG_RST;
            cfg_b_reg <= `SDOS_CFG_RST;
            lim_a_reg <= {`SDOS_LIM_HIGH_RST, `SDOS_LIM_LOW_RST};
            lim_b_reg <= {`SDOS_LIM_HIGH_RST, `SDOS_LIM_LOW_RST};
            tso_reg <= `SDOS_TSO_RST;
            mask_reg <= `SDOS_MASK_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                `SDOS_OFS_CFG_A: cfg_a_reg <= hwdata[3:0];
                `SDOS_OFS_CFG_B: cfg_b_reg <= hwdata[3:0];
                `SDOS_OFS_LIM_A: lim_a_reg <= hwdata;
                `SDOS_OFS_LIM_B: lim_b_reg <= hwdata;
                `SDOS_OFS_TSO: tso_reg <= hwdata[16:0];
                `SDOS_OFS_MASK: mask_reg <= hwdata[2:0];
                default: mask_reg <= mask_reg; // unmapped, ignored
            endcase
        end
    end

    // ----------------------------------------
    // reset flag and sticky status
    // ----------------------------------------
    // reset flag set by reset, cleared by writing 1 to state bit 0
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_flag_reg <= 1'b1;
        end else if (wr_pend_reg && (wr_addr_reg == `SDOS_OFS_STATE) && hwdata[0]) begin
            reset_flag_reg <= 1'b0;
        end
    end

    // events set over read clear, set wins
    always @* begin
        status_next = status_reg;
        if (stat_read) begin
            status_next = {`SDOS_ST_WIDTH{1'b0}};
        end
        if (reset_flag_reg) begin
            status_next[`SDOS_ST_RESET] = 1'b1;
        end
        if (close_next[0] != cur_out[0]) begin
            status_next[`SDOS_ST_CHG_A] = 1'b1;
        end
        if (close_next[1] != cur_out[1]) begin
            status_next[`SDOS_ST_CHG_B] = 1'b1;
        end
    end

    // status and interrupt registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= {`SDOS_ST_WIDTH{1'b0}};
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
        end
    end

    // ----------------------------------------
    // ahb-lite slave: read path
    // ----------------------------------------
    // read mux, unmapped reads zero
    always @* begin
        rd_data_next = 32'h00000000;
        case (haddr)
            `SDOS_OFS_CFG_A: rd_data_next = {28'h0000000, cfg_a_reg};
            `SDOS_OFS_CFG_B: rd_data_next = {28'h0000000, cfg_b_reg};
            `SDOS_OFS_LIM_A: rd_data_next = lim_a_reg;
            `SDOS_OFS_LIM_B: rd_data_next = lim_b_reg;
            `SDOS_OFS_TSO: rd_data_next = {15'h0000, tso_reg};
            `SDOS_OFS_STATUS: rd_data_next = {29'h00000000, status_reg};
            `SDOS_OFS_MASK: rd_data_next = {29'h00000000, mask_reg};
            `SDOS_OFS_STATE: rd_data_next = {29'h00000000, cur_out, reset_flag_reg};
            default: rd_data_next = 32'h00000000;
        endcase
    end

    // read data captured at address phase, zero wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_take) begin
                hrdata <= rd_data_next;
            end
        end
    end
endmodule

// file: dv/sdos_load.sv
`timescale 1ns/1ps
// ----------------------------------------
// dc load on one contact
// ----------------------------------------
module sdos_load (
    input wire hclk, // sampling clock
    input wire contact, // 1 = closed, current flows
    output reg [7:0] closures // open to closed steps seen
);
    reg last = 1'b0; // level at the previous edge
    initial closures = 8'h00;
    // count each step from open to closed
    always @(posedge hclk) begin
        if (contact === 1'b1 && last !== 1'b1) begin
            closures <= closures + 8'h01;
        end
        last <= contact;
    end
endmodule

// file: dv/sdos_top_sva.sv
`timescale 1ns/1ps
`include "sdos_regs.vh"
// ----------------------------------------
// contact checker
// ----------------------------------------
module sdos_top_chk #(
    parameter POS_W = 16
) (
    input wire hclk, // system clock
    input wire hresetn, // async reset, active low
    input wire hsel, // slave select
    input wire [7:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write strobe
    input wire [2:0] hsize, // transfer size
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready in
    input wire [31:0] hrdata, // read data
    input wire hreadyout, // slave ready
    input wire hresp, // response
    input wire power_good, // supply present
    input wire failsafe_in, // failsafe mode
    input wire pos_err_in, // position error
    input wire manual_in, // manual mode
    input wire [POS_W-1:0] pos_in, // position
    input wire contact_out_a, // contact a
    input wire contact_out_b, // contact b
    input wire irq // interrupt
);
    reg [3:0] s1; // first stage of level copies
    reg [3:0] s2; // manual, poserr, failsafe, power as synced
    reg wr_p; // write data phase pending
    reg [7:0] wa; // its address
    reg [3:0] cfg_a; // selector and polarity of a
    reg [3:0] cfg_b; // selector and polarity of b
    reg [31:0] lim_a; // limits of a
    reg [31:0] lim_b; // limits of b
    reg [16:0] tso; // shutoff enable and threshold
    reg rf; // reset-occurred flag copy
    reg [7:0] hit_q; // per code, condition one edge ago
    reg hitb_q; // low limit of b one edge ago
    reg pol_q; // polarity of a one edge ago
    reg polb_q; // polarity of b one edge ago
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------
    // shadow state
    // ----------------------------------------
    // copy of writable state except the mask, updated in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            wr_p <= 1'b0;
            wa <= 8'h00;
            cfg_a <= 4'h0;
            cfg_b <= 4'h0;
            lim_a <= 32'hFFFF0000;
            lim_b <= 32'hFFFF0000;
            tso <= 17'h00000;
            rf <= 1'b1;
        end else begin
            s1 <= {manual_in, pos_err_in, failsafe_in, power_good};
            s2 <= s1;
            wr_p <= hsel && hready && htrans[1] && hwrite;
            wa <= haddr;
            if (wr_p) begin
                case (wa)
                    `SDOS_OFS_CFG_A: cfg_a <= hwdata[3:0];
                    `SDOS_OFS_CFG_B: cfg_b <= hwdata[3:0];
                    `SDOS_OFS_LIM_A: lim_a <= hwdata;
                    `SDOS_OFS_LIM_B: lim_b <= hwdata;
                    `SDOS_OFS_TSO: tso <= hwdata[16:0];
                    `SDOS_OFS_STATE: if (hwdata[0]) rf <= 1'b0;
                    default: ;
                endcase
            end
        end
    end
    // conditions as the block saw them at the last edge
    always @(posedge hclk) begin
        hit_q <= {s2[3], pos_in > lim_a[31:16], pos_in < lim_a[15:0],
            tso[16] && pos_in < tso[15:0], s2[2], rf, s2[1], 1'b0};
        hitb_q <= pos_in < lim_b[15:0];
        pol_q <= cfg_a[3];
        polb_q <= cfg_b[3];
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_unpowered_open: assert property (
        !power_good [*3] |=> !contact_out_a && !contact_out_b) else $error("closed unpowered");
    a_normal_closed: assert property (
        s2[0] && cfg_a[2:0] == 3'h0 |=> contact_out_a) else $error("code 0 not closed");
    a_failsafe_follow: assert property (
        s2[0] && cfg_a[2:0] == 3'h1 |=> contact_out_a == (hit_q[1] ? pol_q : 1'b1))
        else $error("failsafe contact wrong");
    a_reset_latch: assert property (
        s2[0] && cfg_a[2:0] == 3'h2 |=> contact_out_a == (hit_q[2] ? pol_q : 1'b1))
        else $error("reset latch contact wrong");
    a_poserr_follow: assert property (
        s2[0] && cfg_a[2:0] == 3'h3 |=> contact_out_a == (hit_q[3] ? pol_q : 1'b1))
        else $error("position error contact wrong");
    a_shutoff_active: assert property (
        s2[0] && cfg_a[2:0] == 3'h4 |=> contact_out_a == (hit_q[4] ? pol_q : 1'b1))
        else $error("shutoff contact wrong");
    a_low_limit: assert property (
        s2[0] && cfg_a[2:0] == 3'h5 |=> contact_out_a == (hit_q[5] ? pol_q : 1'b1))
        else $error("low limit contact wrong");
    a_high_limit: assert property (
        s2[0] && cfg_a[2:0] == 3'h6 |=> contact_out_a == (hit_q[6] ? pol_q : 1'b1))
        else $error("high limit contact wrong");
    a_manual_follow: assert property (
        s2[0] && cfg_a[2:0] == 3'h7 |=> contact_out_a == (hit_q[7] ? pol_q : 1'b1))
        else $error("manual contact wrong");
    a_second_contact: assert property (
        s2[0] && cfg_b[2:0] == 3'h5 |=> contact_out_b == (hitb_q ? polb_q : 1'b1))
        else $error("contact b wrong");
endmodule
bind sdos_top sdos_top_chk #(.POS_W(POS_W)) i_sdos_top_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .power_good(power_good),
    .failsafe_in(failsafe_in), .pos_err_in(pos_err_in), .manual_in(manual_in),
    .pos_in(pos_in), .contact_out_a(contact_out_a), .contact_out_b(contact_out_b), .irq(irq));

// file: dv/sdos_top_tb.sv
`timescale 1ns/1ps
`include "sdos_regs.vh"
// ----------------------------------------
// contact block testbench
// ----------------------------------------
module sdos_top_tb;
    reg hclk = 1'b0; // bus clock
    reg hresetn; // reset, active low
    reg hsel; // select
    reg [7:0] haddr; // address
    reg [1:0] htrans; // transfer type
    reg hwrite; // write strobe
    reg [31:0] hwdata; // write data
    reg power_good, failsafe_in, pos_err_in, manual_in; // status levels
    reg [15:0] pos_in; // position
    wire [31:0] hrdata; // read data
    wire hreadyout, hresp, contact_out_a, contact_out_b, irq; // outputs
    wire [7:0] na, nb; // closures seen by the loads
    logic [31:0] d; // read result
    int errors = 0; // mismatches
    int checks_done = 0; // comparisons
    int cycles = 0; // timeout count
    always #25 hclk = ~hclk; // 20 MHz
    sdos_top i_sdos_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_good(power_good),
        .failsafe_in(failsafe_in), .pos_err_in(pos_err_in), .manual_in(manual_in),
        .pos_in(pos_in), .contact_out_a(contact_out_a), .contact_out_b(contact_out_b), .irq(irq));
    sdos_load i_sdos_load_a (.hclk(hclk), .contact(contact_out_a), .closures(na));
    sdos_load i_sdos_load_b (.hclk(hclk), .contact(contact_out_b), .closures(nb));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        xfer(a, 1'b1, wd);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h00000000);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge hclk);
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // drive one condition on or off; code 0 raises failsafe, position error, manual and low limit
    task automatic stim(input int c, input int on);
        failsafe_in <= (c == 1 || c == 0) && on;
        pos_err_in <= (c == 3 || c == 0) && on;
        manual_in <= (c == 7 || c == 0) && on;
        case (c)
            0: pos_in <= on ? 16'h0900 : 16'h4000;
            4: pos_in <= on ? 16'h07FF : 16'h0800;
            5: pos_in <= on ? 16'h0FFF : 16'h1000;
            6: pos_in <= on ? 16'h9001 : 16'h9000;
            default: pos_in <= 16'h4000;
        endcase
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults();
        logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20};
        logic [31:0] rv [7] = '{0, 0, 32'hFFFF0000, 32'hFFFF0000, 0, 0, 0};
        wr(8'h20, 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk(d, rv[i]);
        end
        rd(`SDOS_OFS_STATUS);
        chk(d & 32'h1, 32'h1);
        chk({contact_out_b, contact_out_a}, 32'h3);
        chk(hresp, 32'h0);
    endtask
    task automatic t_latch();
        wr(`SDOS_OFS_CFG_A, 32'h2);
        settle();
        chk(contact_out_a, 32'h0);
        wr(`SDOS_OFS_STATE, 32'h1);
        settle();
        chk(contact_out_a, 32'h1);
        rd(`SDOS_OFS_STATE);
        chk(d & 32'h1, 32'h0);
    endtask
    task automatic t_codes();
        wr(`SDOS_OFS_TSO, 32'h00010800);
        wr(`SDOS_OFS_LIM_A, 32'h90001000);
        wr(`SDOS_OFS_LIM_B, 32'hFFFF0100);
        wr(`SDOS_OFS_CFG_B, 32'h5);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                if (c == 2) continue;
                wr(`SDOS_OFS_CFG_A, 32'(p * 8 + c));
                for (int on = 0; on < 2; on++) begin
                    stim(c, on);
                    settle();
                    chk(contact_out_a, 32'((c != 0 && on) ? p : 1));
                    chk(contact_out_b, 32'h1);
                end
            end
        end
        pos_in <= 16'h00FF;
        settle();
        chk(contact_out_b, 32'h0);
    endtask
    task automatic t_irq();
        rd(`SDOS_OFS_STATUS);
        wr(`SDOS_OFS_MASK, 32'h2);
        wr(`SDOS_OFS_CFG_A, 32'h7);
        manual_in <= 1'b1;
        settle();
        chk(irq, 32'h1);
        rd(`SDOS_OFS_STATUS);
        chk(d & 32'h2, 32'h2);
        @(posedge hclk);
        chk(irq, 32'h0);
        wr(`SDOS_OFS_MASK, 32'h0);
        manual_in <= 1'b0;
        settle();
        chk(irq, 32'h0);
        rd(`SDOS_OFS_STATUS);
        chk(d & 32'h2, 32'h2);
    endtask
    task automatic t_power();
        logic [7:0] n;
        logic [7:0] m;
        power_good <= 1'b0;
        settle();
        chk({contact_out_b, contact_out_a}, 32'h0);
        n = na;
        m = nb;
        power_good <= 1'b1;
        settle();
        // the load counts one edge after the contact closes
        @(posedge hclk);
        chk(na - n, 32'h1);
        chk(nb - m, 32'h0);
    endtask
    // ----------------------------------------
    // main sequence and timeout
    // ----------------------------------------
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            close_out();
        end
    end
    initial begin
        hsel <= 1'b0;
        haddr <= 8'h00;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= 32'h00000000;
        power_good <= 1'b1;
        stim(1, 0);
        do_reset();
        t_defaults();
        t_latch();
        t_codes();
        t_irq();
        t_power();
        do_reset();
        t_latch(); // a second reset raises the flag again
        close_out();
    end
endmodule
